// file: src/tpwm_timer.sv
// Behaviour
// - overflow toggles pin when toggle_on_wrap set
// - width runs from overflow to compare match
// - period 255 undivided gives 256 clocks
// - value 128 of 256 gives half duty
// - compare uses live value, passed values miss
// - buffered bit links channels onto channel 0 pin
// - last written pair takes over at overflow
// - buffered: channel 0 control, channel 1 pin freed
// - buffered bit beats single mode bit
// - no toggle on wrap gives constant 0%
// - full duty plus toggle gives 100%
// - overflow flag on wrap, interrupt if enabled
// - channel flag on capture/compare, interrupt if enabled
// - wait mode: runs, registers locked, irq wakes
// - stop mode freezes all state
// - break halts counter and blocks captures
// - break clears allowed when clear-allow high
// - break protects flags when clear-allow low
// - divider select 1..64 or external clock pin
// - overflow flag cleared by read-then-write-zero only
// - counter clear bit resets counter, reads zero
`timescale 1ns/1ns
`default_nettype none
module tpwm_timer #(
  parameter int CNT_W = 16
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              cpu_wait,
  input  wire logic              stop_mode,
  input  wire logic              break_active,
  input  wire logic              break_clear_allow,
  input  wire logic              ext_count_clock_pin,
  input  wire logic              chan0_pin_in,
  output var  logic              chan0_pin_out,
  output var  logic              chan0_pin_oe,
  input  wire logic              chan1_pin_in,
  output var  logic              chan1_pin_out,
  output var  logic              chan1_pin_oe,
  output logic                   irq,
  output logic                   wake_req
);
  // stop mode freezes everything, same as the clock enable
  logic run;
  assign run = clk_en & ~stop_mode;

  // ---------------- bus ----------------
  logic setup_ph;
  logic access_ph;
  logic wr_ok;
  logic rd_ok;
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable & run;
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & cpu_wait;
  assign wr_ok     = access_ph & pwrite & ~cpu_wait;
  assign rd_ok     = access_ph & ~pwrite & ~cpu_wait;

  // status bits may only change in break when software is allowed to
  logic flag_access_ok;
  assign flag_access_ok = ~break_active | break_clear_allow;

  // ---------------- control registers ----------------
  logic             overflow_flag;
  logic             overflow_irq_en;
  logic             counter_halt;
  logic [2:0]       clk_div_sel;
  logic [CNT_W-1:0] period_value;
  logic [CNT_W-1:0] count;
  logic [6:0]       prescale;
  logic             ovf_armed;
  logic             ext_prev;

  logic wr_sc;
  logic counter_clear;
  assign wr_sc         = wr_ok && paddr == tpwm_pkg::ADDR_STATUS_CTRL;
  assign counter_clear = wr_sc & pwdata[tpwm_pkg::SC_CLEAR];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq_en <= 1'b0;
      counter_halt    <= 1'b1;
      clk_div_sel     <= 3'h0;
    end else if (run && wr_sc) begin
      overflow_irq_en <= pwdata[tpwm_pkg::SC_IRQ_EN];
      counter_halt    <= pwdata[tpwm_pkg::SC_HALT];
      clk_div_sel     <= pwdata[tpwm_pkg::SC_DIV_HI:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_value <= tpwm_pkg::PERIOD_RESET;
    end else if (run && wr_ok && paddr == tpwm_pkg::ADDR_PERIOD) begin
      period_value <= pwdata[CNT_W-1:0];
    end
  end

  // ---------------- prescaler and counter ----------------
  logic [6:0] div_mask;
  logic       tick;
  logic       ext_rise;
  logic       count_run;
  logic       wrap;
  logic [CNT_W-1:0] next_count;

  assign div_mask  = tpwm_pkg::PRESCALE_ONES >> (tpwm_pkg::DIV_EXT_CLOCK - clk_div_sel);
  assign ext_rise  = ext_count_clock_pin & ~ext_prev;
  assign count_run = ~counter_halt & ~break_active;
  always_comb begin
    if (clk_div_sel == tpwm_pkg::DIV_EXT_CLOCK) begin
      tick = count_run & ext_rise;
    end else begin
      tick = count_run && (prescale & div_mask) == div_mask;
    end
  end
  assign wrap       = tick && count == period_value;
  assign next_count = wrap ? tpwm_pkg::COUNT_ZERO : count + 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev <= 1'b0;
    end else if (run) begin
      ext_prev <= ext_count_clock_pin;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= tpwm_pkg::PRESCALE_ZERO;
      count    <= tpwm_pkg::COUNT_ZERO;
    end else if (run) begin
      if (counter_clear) begin
        prescale <= tpwm_pkg::PRESCALE_ZERO;
        count    <= tpwm_pkg::COUNT_ZERO;
      end else if (count_run) begin
        prescale <= prescale + 1'b1;
        if (tick) begin
          count <= next_count;
        end
      end
    end
  end

  // read arms the clear; a later overflow disarms it so it is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
      ovf_armed     <= 1'b0;
    end else if (run) begin
      if (wrap) begin
        overflow_flag <= 1'b1;
        ovf_armed     <= 1'b0;
      end else if (wr_sc && flag_access_ok && ovf_armed && !pwdata[tpwm_pkg::SC_FLAG]) begin
        overflow_flag <= 1'b0;
        ovf_armed     <= 1'b0;
      end else if (rd_ok && flag_access_ok && overflow_flag &&
                   paddr == tpwm_pkg::ADDR_STATUS_CTRL) begin
        ovf_armed <= 1'b1;
      end
    end
  end

  // ---------------- channels ----------------
  logic [1:0]       chan_event_flag;
  logic [1:0]       chan_irq_en;
  logic             buffered_mode_sel;
  logic [1:0]       single_mode_bit;
  logic [1:0]       edge_level_sel_hi;
  logic [1:0]       edge_level_sel_lo;
  logic [1:0]       toggle_on_wrap;
  logic [1:0]       full_duty_sel;
  logic [CNT_W-1:0] chan_value [2];
  logic [1:0]       chan_out;
  logic [1:0]       chan_in_prev;
  logic [1:0]       chan_event;
  logic [1:0]       chan_is_out;
  logic [1:0]       chan_pin_in;
  logic [7:0]       chan_ctrl_rd [2];
  logic             active_pair;
  logic             last_written;

  assign chan_pin_in = {chan1_pin_in, chan0_pin_in};

  // buffered pairing: last written pair wins at each overflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_pair  <= 1'b0;
      last_written <= 1'b0;
    end else if (run) begin
      if (!buffered_mode_sel) begin
        active_pair  <= 1'b0;
        last_written <= 1'b0;
      end else begin
        if (wr_ok && paddr == tpwm_pkg::ADDR_CH0_VALUE) begin
          last_written <= 1'b0;
        end else if (wr_ok && paddr == tpwm_pkg::ADDR_CH1_VALUE) begin
          last_written <= 1'b1;
        end
        if (wrap) begin
          active_pair <= last_written;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffered_mode_sel <= 1'b0;
    end else if (run && wr_ok && paddr == tpwm_pkg::ADDR_CH0_CTRL) begin
      buffered_mode_sel <= pwdata[tpwm_pkg::CC_BUF];
    end
  end

  for (genvar c = 0; c < 2; c++) begin : g_chan
    localparam logic [7:0] CTRL_ADDR = c == 0 ? tpwm_pkg::ADDR_CH0_CTRL
                                              : tpwm_pkg::ADDR_CH1_CTRL;
    localparam logic [7:0] VAL_ADDR  = c == 0 ? tpwm_pkg::ADDR_CH0_VALUE
                                              : tpwm_pkg::ADDR_CH1_VALUE;
    logic             wr_ctrl;
    logic             unused_ch;
    logic             out_mode;
    logic [1:0]       els;
    logic [CNT_W-1:0] cmp_value;
    logic             match;
    logic             cap_edge;
    logic             armed;
    logic             drive_level;

    assign wr_ctrl   = wr_ok && paddr == CTRL_ADDR;
    assign unused_ch = (c == 1) & buffered_mode_sel;
    // buffered takes precedence over single mode
    assign out_mode  = (c == 0) ? (buffered_mode_sel | single_mode_bit[c])
                                : single_mode_bit[c];
    assign els       = {edge_level_sel_hi[c], edge_level_sel_lo[c]};
    assign cmp_value = (c == 0 && active_pair) ? chan_value[1] : chan_value[c];
    // live value compared, so a value already passed misses this period
    assign match     = tick && next_count == cmp_value && out_mode && !unused_ch;
    always_comb begin
      unique case (els)
        tpwm_pkg::ELS_OFF:    cap_edge = 1'b0;
        tpwm_pkg::ELS_TOGGLE: cap_edge = chan_pin_in[c] & ~chan_in_prev[c];
        tpwm_pkg::ELS_CLEAR:  cap_edge = ~chan_pin_in[c] & chan_in_prev[c];
        tpwm_pkg::ELS_SET:    cap_edge = chan_pin_in[c] ^ chan_in_prev[c];
      endcase
    end
    assign chan_event[c] = match |
      (cap_edge & ~out_mode & ~unused_ch & ~break_active & ~counter_halt);
    assign chan_is_out[c] = out_mode & ~unused_ch & (els != tpwm_pkg::ELS_OFF);
    // full duty shows the pulse level, which is the opposite of the compare action
    assign drive_level = (full_duty_sel[c] & toggle_on_wrap[c]) ?
                         ~edge_level_sel_lo[c] : chan_out[c];

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        chan_irq_en[c]       <= 1'b0;
        single_mode_bit[c]   <= 1'b0;
        edge_level_sel_hi[c] <= 1'b0;
        edge_level_sel_lo[c] <= 1'b0;
        toggle_on_wrap[c]    <= 1'b0;
        full_duty_sel[c]     <= 1'b0;
      end else if (run && wr_ctrl && !unused_ch) begin
        chan_irq_en[c]       <= pwdata[tpwm_pkg::CC_IRQ_EN];
        single_mode_bit[c]   <= pwdata[tpwm_pkg::CC_SINGLE];
        edge_level_sel_hi[c] <= pwdata[tpwm_pkg::CC_ELS_HI];
        edge_level_sel_lo[c] <= pwdata[tpwm_pkg::CC_ELS_LO];
        toggle_on_wrap[c]    <= pwdata[tpwm_pkg::CC_TOGGLE];
        full_duty_sel[c]     <= pwdata[tpwm_pkg::CC_FULL];
      end
    end

    // value register; a capture loads the counter into it
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        chan_value[c] <= tpwm_pkg::COUNT_ZERO;
      end else if (run) begin
        if (chan_event[c] && !out_mode) begin
          chan_value[c] <= count;
        end else if (wr_ok && paddr == VAL_ADDR) begin
          chan_value[c] <= pwdata[CNT_W-1:0];
        end
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        chan_in_prev[c] <= 1'b0;
      end else if (run) begin
        chan_in_prev[c] <= chan_pin_in[c];
      end
    end

    // overflow toggle first, then compare forces its level
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        chan_out[c] <= 1'b0;
      end else if (run && out_mode && !unused_ch) begin
        if (match) begin
          unique case (els)
            tpwm_pkg::ELS_OFF:    chan_out[c] <= wrap && toggle_on_wrap[c] ?
                                                 ~chan_out[c] : chan_out[c];
            tpwm_pkg::ELS_TOGGLE: chan_out[c] <= (wrap && toggle_on_wrap[c]) ?
                                                 chan_out[c] : ~chan_out[c];
            tpwm_pkg::ELS_CLEAR:  chan_out[c] <= 1'b0;
            tpwm_pkg::ELS_SET:    chan_out[c] <= 1'b1;
          endcase
        end else if (wrap && toggle_on_wrap[c]) begin
          chan_out[c] <= ~chan_out[c];
        end
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        chan_event_flag[c] <= 1'b0;
        armed              <= 1'b0;
      end else if (run) begin
        if (chan_event[c] || (c == 0 && chan_event[1] && buffered_mode_sel)) begin
          chan_event_flag[c] <= 1'b1;
          armed              <= 1'b0;
        end else if (wr_ctrl && flag_access_ok && armed && !pwdata[tpwm_pkg::CC_FLAG]) begin
          chan_event_flag[c] <= 1'b0;
          armed              <= 1'b0;
        end else if (rd_ok && flag_access_ok && chan_event_flag[c] &&
                     paddr == CTRL_ADDR) begin
          armed <= 1'b1;
        end
      end
    end

    assign chan_ctrl_rd[c] = unused_ch ? 8'h00 :
      {chan_event_flag[c], chan_irq_en[c], (c == 0) & buffered_mode_sel,
       single_mode_bit[c], edge_level_sel_hi[c], edge_level_sel_lo[c],
       toggle_on_wrap[c], full_duty_sel[c]};
  end

  // buffered output rides on the channel 0 pin only
  assign chan0_pin_out = g_chan[0].drive_level;
  assign chan0_pin_oe  = chan_is_out[0];
  assign chan1_pin_out = g_chan[1].drive_level;
  assign chan1_pin_oe  = chan_is_out[1];

  // ---------------- interrupt and wake ----------------
  assign irq = (overflow_flag & overflow_irq_en) |
               (|(chan_event_flag & chan_irq_en));
  assign wake_req = irq;

  // ---------------- read data ----------------
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      tpwm_pkg::ADDR_STATUS_CTRL:
        next_prdata[7:0] = {overflow_flag, overflow_irq_en, counter_halt,
                            1'b0, 1'b0, clk_div_sel};
      tpwm_pkg::ADDR_COUNTER:   next_prdata[CNT_W-1:0] = count;
      tpwm_pkg::ADDR_PERIOD:    next_prdata[CNT_W-1:0] = period_value;
      tpwm_pkg::ADDR_CH0_CTRL:  next_prdata[7:0] = chan_ctrl_rd[0];
      tpwm_pkg::ADDR_CH0_VALUE: next_prdata[CNT_W-1:0] = chan_value[0];
      tpwm_pkg::ADDR_CH1_CTRL:  next_prdata[7:0] = chan_ctrl_rd[1];
      tpwm_pkg::ADDR_CH1_VALUE: next_prdata[CNT_W-1:0] = chan_value[1];
      default:                  next_prdata = 32'h0000_0000;
    endcase
    if (cpu_wait) begin
      next_prdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (run && setup_ph && !pwrite) begin
      prdata <= next_prdata;
    end
  end
endmodule
`default_nettype wire

// file: include/tpwm_pkg.sv
package tpwm_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_STATUS_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COUNTER     = 8'h04;
  localparam logic [7:0] ADDR_PERIOD      = 8'h08;
  localparam logic [7:0] ADDR_CH0_CTRL    = 8'h0c;
  localparam logic [7:0] ADDR_CH0_VALUE   = 8'h10;
  localparam logic [7:0] ADDR_CH1_CTRL    = 8'h14;
  localparam logic [7:0] ADDR_CH1_VALUE   = 8'h18;

  // timer_status_ctrl fields
  localparam int SC_FLAG   = 7;
  localparam int SC_IRQ_EN = 6;
  localparam int SC_HALT   = 5;
  localparam int SC_CLEAR  = 4;
  localparam int SC_DIV_HI = 2;

  // channel status ctrl fields
  localparam int CC_FLAG   = 7;
  localparam int CC_IRQ_EN = 6;
  localparam int CC_BUF    = 5;
  localparam int CC_SINGLE = 4;
  localparam int CC_ELS_HI = 3;
  localparam int CC_ELS_LO = 2;
  localparam int CC_TOGGLE = 1;
  localparam int CC_FULL   = 0;

  localparam logic [2:0]  DIV_EXT_CLOCK   = 3'h7;
  localparam logic [15:0] PERIOD_RESET    = 16'hffff;
  localparam logic [15:0] COUNT_ZERO      = 16'h0000;
  localparam logic [6:0]  PRESCALE_ZERO   = 7'h00;
  localparam logic [6:0]  PRESCALE_ONES   = 7'h7f;
  localparam logic [1:0]  ELS_OFF         = 2'h0;
  localparam logic [1:0]  ELS_TOGGLE      = 2'h1;
  localparam logic [1:0]  ELS_CLEAR       = 2'h2;
  localparam logic [1:0]  ELS_SET         = 2'h3;
endpackage

// file: testbench/tpwm_timer_chk.sv
`timescale 1ns/1ns
`default_nettype none
module tpwm_timer_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cpu_wait,
  input wire logic        stop_mode,
  input wire logic        chan0_pin_out,
  input wire logic        chan1_pin_oe,
  input wire logic        irq,
  input wire logic        wake_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       live;
  logic [7:0] ch0_ctrl;
  logic       ovf_en;
  logic       ch1_en;
  assign live = psel && penable && !cpu_wait && clk_en && !stop_mode;
  // mirrors of written control bits, so port-level rules can be judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch0_ctrl <= 8'h00;
      ovf_en   <= 1'b0;
      ch1_en   <= 1'b0;
    end else if (live && pwrite) begin
      if (paddr == tpwm_pkg::ADDR_STATUS_CTRL) ovf_en <= pwdata[tpwm_pkg::SC_IRQ_EN];
      if (paddr == tpwm_pkg::ADDR_CH0_CTRL) ch0_ctrl <= pwdata[7:0];
      if (paddr == tpwm_pkg::ADDR_CH1_CTRL && !ch0_ctrl[tpwm_pkg::CC_BUF])
        ch1_en <= pwdata[tpwm_pkg::CC_IRQ_EN];
    end
  end
  a_ready_high: assert property (psel && penable |-> pready) else $error("pready low");
  a_wait_refused: assert property (psel && penable |-> pslverr == cpu_wait)
    else $error("pslverr does not follow wait");
  a_wake_irq: assert property (wake_req == irq) else $error("wake differs from irq");
  a_wait_read_zero: assert property (psel && penable && !pwrite && cpu_wait && $past(cpu_wait)
    |-> prdata == 32'h0) else $error("read in wait not zero");
  a_stop_freeze: assert property (stop_mode && $past(stop_mode)
    |-> $stable(chan0_pin_out) && $stable(irq)) else $error("state moved in stop");
  a_ch1_pin_free: assert property (ch0_ctrl[tpwm_pkg::CC_BUF] |-> !chan1_pin_oe)
    else $error("chan1 pin driven in buffered mode");
  a_ch1_ctrl_blank: assert property (live && !pwrite && paddr == tpwm_pkg::ADDR_CH1_CTRL
    && ch0_ctrl[tpwm_pkg::CC_BUF] |-> prdata == 32'h0) else $error("chan1 ctrl not blank");
  a_irq_masked: assert property (!ovf_en && !ch0_ctrl[tpwm_pkg::CC_IRQ_EN] && !ch1_en
    |-> !irq) else $error("irq while all enables off");
  a_clear_reads_zero: assert property (live && !pwrite && paddr == tpwm_pkg::ADDR_STATUS_CTRL
    |-> !prdata[tpwm_pkg::SC_CLEAR]) else $error("counter clear bit reads one");
  a_unmapped_zero: assert property (live && !pwrite && paddr > tpwm_pkg::ADDR_CH1_VALUE
    |-> prdata == 32'h0) else $error("unmapped read not zero");
  a_full_duty_high: assert property (ch0_ctrl[5:0] == 6'h1b |-> chan0_pin_out)
    else $error("full duty pin low");
  a_no_wrap_flat: assert property (ch0_ctrl[5:0] == 6'h18 && $past(ch0_ctrl[5:0], 2) == 6'h18
    |-> !$rose(chan0_pin_out)) else $error("pin rose without wrap toggle");
endmodule
bind tpwm_timer tpwm_timer_chk tpwm_timer_chk_i (.pclk, .presetn, .clk_en, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_wait, .stop_mode, .chan0_pin_out,
  .chan1_pin_oe, .irq, .wake_req);
`default_nettype wire

// file: testbench/tpwm_load.sv
`timescale 1ns/1ns
`default_nettype none
module tpwm_load (
  input wire logic  pclk,
  input wire logic  pin_out,
  input wire logic  pin_oe,
  output logic      pin_level,
  output int        period_cnt,
  output int        high_cnt
);
  int   run_cnt = 0;
  int   run_high = 0;
  logic last = 1'b0;
  // pull-down load: a released pin reads low
  assign pin_level = pin_oe & pin_out;
  initial period_cnt = 0;
  initial high_cnt = 0;
  always @(posedge pclk) begin
    last <= pin_level;
    if (pin_level && !last) begin
      period_cnt <= run_cnt;
      high_cnt   <= run_high;
      run_cnt    <= 1;
      run_high   <= 1;
    end else begin
      run_cnt  <= run_cnt + 1;
      run_high <= run_high + int'(pin_level);
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        cpu_wait = 1'b0;
  logic        stop_mode = 1'b0;
  logic        brk = 1'b0;
  logic        allow = 1'b0;
  logic        ext_clk = 1'b0;
  logic        clk_en = 1'b1;
  logic        c1_drv = 1'b0;
  logic [31:0] q;
  logic [31:0] c1;
  logic        err;
  wire logic [31:0] prdata;
  wire logic   pready, pslverr, c0o, c0e, c1o, c1e, irq, wake_req, c0_lvl;
  int          period_cnt, high_cnt, v;
  int          bad_count = 0;
  int          total_checks = 0;

  tpwm_timer tpwm_timer_i (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cpu_wait, .stop_mode, .break_active(brk),
    .break_clear_allow(allow), .ext_count_clock_pin(ext_clk), .chan0_pin_in(c0_lvl),
    .chan0_pin_out(c0o), .chan0_pin_oe(c0e), .chan1_pin_in(c1_drv), .chan1_pin_out(c1o),
    .chan1_pin_oe(c1e), .irq, .wake_req);
  tpwm_load tpwm_load_i (.pclk, .pin_out(c0o), .pin_oe(c0e), .pin_level(c0_lvl), .period_cnt,
    .high_cnt);

  always #4 pclk = ~pclk;
  always begin
    repeat (4) @(posedge pclk);
    ext_clk <= ~ext_clk;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic int div_of(input int code);
    return (code == 7) ? 8 : (1 << code);
  endfunction
  // halt and clear, period, width, mode, then release; never toggle on compare
  task automatic init(input int dv, input int per, input int w, input logic [7:0] ctl);
    apb(1'b1, tpwm_pkg::ADDR_STATUS_CTRL, 32'h30);
    apb(1'b1, tpwm_pkg::ADDR_PERIOD, per);
    apb(1'b1, tpwm_pkg::ADDR_CH0_VALUE, w);
    apb(1'b1, tpwm_pkg::ADDR_CH0_CTRL, {24'h0, ctl});
    apb(1'b1, tpwm_pkg::ADDR_STATUS_CTRL, dv);
  endtask
  task automatic pwm(input int p, input int h);
    repeat (3 * p + 8) @(posedge pclk);
    check(period_cnt, p);
    check(high_cnt, h);
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    final_report();
  end

  initial begin
    void'($urandom(32'hb7fa6cba));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, tpwm_pkg::ADDR_COUNTER, 0);
    check(q, 32'h0);
    apb(1'b0, tpwm_pkg::ADDR_STATUS_CTRL, 0);
    check(q, 32'h20);
    apb(1'b0, 8'h1c, 0);
    $display("test reset done");
    init(0, 255, 128, 8'h1a);
    pwm(256, 128);
    c1 = 128;
    for (int i = 0; i < 4; i++) begin
      v = 1 + int'($urandom % 254);
      // shorter widths after the compare, longer ones after the overflow
      if (v < c1) @(negedge c0_lvl); else @(posedge c0_lvl);
      apb(1'b1, tpwm_pkg::ADDR_CH0_VALUE, v);
      pwm(256, v);
      c1 = v;
    end
    $display("test width done");
    apb(1'b1, tpwm_pkg::ADDR_STATUS_CTRL, 32'h60);
    apb(1'b0, tpwm_pkg::ADDR_STATUS_CTRL, 0);
    check(q, 32'he0);
    check(irq, 1'b1);
    apb(1'b0, tpwm_pkg::ADDR_CH0_CTRL, 0);
    check(q[7], 1'b1);
    apb(1'b1, tpwm_pkg::ADDR_STATUS_CTRL, 32'h60);
    apb(1'b1, tpwm_pkg::ADDR_STATUS_CTRL, 32'he0);
    apb(1'b0, tpwm_pkg::ADDR_STATUS_CTRL, 0);
    check(q, 32'h60);
    check(irq, 1'b0);
    $display("test flags done");
    apb(1'b1, tpwm_pkg::ADDR_STATUS_CTRL, 0);
    repeat (300) @(posedge pclk);
    brk <= 1'b1;
    apb(1'b0, tpwm_pkg::ADDR_STATUS_CTRL, 0);
    check(q[7], 1'b1);
    apb(1'b1, tpwm_pkg::ADDR_STATUS_CTRL, 0);
    apb(1'b0, tpwm_pkg::ADDR_COUNTER, 0);
    c1 = q;
    repeat (20) @(posedge pclk);
    apb(1'b0, tpwm_pkg::ADDR_COUNTER, 0);
    check(q, c1);
    apb(1'b0, tpwm_pkg::ADDR_STATUS_CTRL, 0);
    check(q[7], 1'b1);
    allow <= 1'b1;
    apb(1'b0, tpwm_pkg::ADDR_STATUS_CTRL, 0);
    apb(1'b1, tpwm_pkg::ADDR_STATUS_CTRL, 32'h20);
    brk <= 1'b0;
    allow <= 1'b0;
    apb(1'b0, tpwm_pkg::ADDR_STATUS_CTRL, 0);
    check(q[7], 1'b0);
    $display("test break done");
    cpu_wait <= 1'b1;
    apb(1'b1, tpwm_pkg::ADDR_PERIOD, 32'h1234);
    check(err, 1'b1);
    apb(1'b0, tpwm_pkg::ADDR_PERIOD, 0);
    check(q, 32'h0);
    cpu_wait <= 1'b0;
    apb(1'b0, tpwm_pkg::ADDR_PERIOD, 0);
    check(q, 32'hff);
    apb(1'b1, tpwm_pkg::ADDR_STATUS_CTRL, 0);
    apb(1'b0, tpwm_pkg::ADDR_COUNTER, 0);
    c1 = q;
    stop_mode <= 1'b1;
    repeat (50) @(posedge pclk);
    stop_mode <= 1'b0;
    clk_en <= 1'b0;
    repeat (50) @(posedge pclk);
    clk_en <= 1'b1;
    apb(1'b0, tpwm_pkg::ADDR_COUNTER, 0);
    check(((q - c1) & 32'hff) < 32'h8, 1'b1);
    $display("test low power done");
    for (int code = 0; code < 8; code++) begin
      init(code, 15, 8, 8'h1a);
      pwm(16 * div_of(code), 8 * div_of(code));
    end
    $display("test prescale done");
    init(0, 255, 64, 8'h3a);
    pwm(256, 64);
    apb(1'b1, tpwm_pkg::ADDR_CH1_VALUE, 200);
    pwm(256, 200);
    apb(1'b1, tpwm_pkg::ADDR_CH0_VALUE, 32);
    pwm(256, 32);
    apb(1'b0, tpwm_pkg::ADDR_CH1_CTRL, 0);
    check(q, 32'h0);
    check(c1e, 1'b0);
    $display("test buffered done");
    apb(1'b1, tpwm_pkg::ADDR_CH0_CTRL, 32'h18);
    // channel 1 as rising-edge capture; break must hide the first edge
    apb(1'b1, tpwm_pkg::ADDR_CH1_CTRL, 32'h04);
    brk <= 1'b1;
    c1_drv <= 1'b1;
    @(posedge pclk);
    apb(1'b0, tpwm_pkg::ADDR_CH1_CTRL, 0);
    check(q[7], 1'b0);
    brk <= 1'b0;
    c1_drv <= 1'b0;
    @(posedge pclk);
    c1_drv <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, tpwm_pkg::ADDR_CH1_CTRL, 0);
    check(q[7], 1'b1);
    brk <= 1'b1;
    apb(1'b1, tpwm_pkg::ADDR_CH1_CTRL, 32'h04);
    apb(1'b0, tpwm_pkg::ADDR_CH1_CTRL, 0);
    check(q[7], 1'b1);
    brk <= 1'b0;
    apb(1'b1, tpwm_pkg::ADDR_CH1_CTRL, 32'h04);
    apb(1'b0, tpwm_pkg::ADDR_CH1_CTRL, 0);
    check(q[7], 1'b0);
    apb(1'b1, tpwm_pkg::ADDR_CH1_CTRL, 32'h1b);
    repeat (600) @(posedge pclk);
    check(c0o, 1'b0);
    check(c1o, 1'b1);
    check(c1e, 1'b1);
    apb(1'b1, tpwm_pkg::ADDR_CH0_CTRL, 32'h1b);
    repeat (300) @(posedge pclk);
    check(c0o, 1'b1);
    $display("test duty limits done");
    final_report();
  end
endmodule
`default_nettype wire
